/* File: logic/frc_pkg.sv */
// What this block does
// RULE1: Reset loads read config with async bit set
// RULE2: Read config bit 15 selects async or burst
// RULE3: Bits 14:11 give latency 3 to 12
// RULE4: Latency counts from address latch clock edge
// RULE5: Read config bit 10 sets wait polarity
// RULE6: Read config bit 8 sets wait timing
// RULE7: Bits 2:0 select 8, 16, continuous burst
// RULE8: Host clears wait delay with hold and code 2
// RULE9: Host writes zero to reserved bits
// RULE10: Read config changes only by its command
// RULE11: Info mode offset 05h returns read config
// RULE12: Info mode offset 06h returns power config
// RULE13: Power config resets to 0004h
// RULE14: Power config bit 15 enables deep sleep
// RULE15: Power config bit 14 sets sleep pin level
// RULE16: Bits 2:0 drive strength, default four
// RULE17: Host writes setup 0060h, confirm 0004h
// RULE18: Write between setup and confirm is error
// RULE19: Setup cycle enters status read mode
// RULE20: Confirm loads register, enters array read
// RULE21: Config write ignores programming supply level
// RULE22: Host picks latency for its clock rate
// RULE23: Host enters info mode with 0090h
// RULE24: Sequence error sets status bits 4 and 5
// RULE25: Read config write uses same two-cycle form
`default_nettype none
package frc_pkg;
    localparam logic [15:0] CMD_CFG_SETUP    = 16'h0060;
    localparam logic [15:0] CMD_PWR_CONFIRM  = 16'h0004;
    localparam logic [15:0] CMD_RD_CONFIRM   = 16'h0003;
    localparam logic [15:0] CMD_READ_ARRAY   = 16'h00ff;
    localparam logic [15:0] CMD_READ_STATUS  = 16'h0070;
    localparam logic [15:0] CMD_READ_INFO    = 16'h0090;
    localparam logic [15:0] CMD_CFI_QUERY    = 16'h0098;
    localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
    localparam logic [7:0]  OFS_READ_CFG     = 8'h05;
    localparam logic [7:0]  OFS_POWER_CFG    = 8'h06;
    localparam logic [15:0] READ_CFG_RESET   = 16'hb907;
    localparam logic [15:0] POWER_CFG_RESET  = 16'h0004;
    localparam logic [15:0] STATUS_READY     = 16'h0080;
    localparam logic [15:0] STATUS_SEQ_ERR   = 16'h0030;
    localparam int RC_MODE = 15;
    localparam int RC_LAT_HI = 14;
    localparam int RC_LAT_LO = 11;
    localparam int RC_WAIT_POL = 10;
    localparam int RC_WAIT_DLY = 8;
    localparam int PC_SLEEP_EN = 15;
    localparam int PC_SLEEP_POL = 14;
    localparam logic [3:0] LAT_MIN = 4'h3;
    localparam logic [3:0] LAT_MAX = 4'hc;
    localparam logic [2:0] BURST_8 = 3'h2;
    localparam logic [2:0] BURST_16 = 3'h3;
    localparam logic [2:0] BURST_CONT = 3'h7;
    localparam logic [2:0] DRIVE_MIN = 3'h1;
    localparam logic [2:0] DRIVE_MAX = 3'h6;

    typedef enum logic [1:0] {
        MODE_ARRAY  = 2'b00,
        MODE_STATUS = 2'b01,
        MODE_INFO   = 2'b10,
        MODE_CFI    = 2'b11
    } frc_mode_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAIT = 2'b01
    } frc_seq_e;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [15:0] wdata;
    } frc_bus_s;

    typedef struct packed {
        logic [3:0] latency;
        logic       burst_mode;
        logic       wait_active_high;
        logic       wait_early;
        logic [4:0] burst_words;
        logic       burst_wrap;
    } frc_rdcfg_s;
endpackage
`default_nettype wire

/* File: logic/frc_sync.sv */
`default_nettype none
module frc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } frc_sync_s;
    frc_sync_s st;
    frc_sync_s next_st;

    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule
`default_nettype wire

/* File: logic/frc_decode.sv */
`default_nettype none
module frc_decode (
    input  wire logic [15:0]         read_cfg,
    output frc_pkg::frc_rdcfg_s      cfg
);
    // ******************************
    // Field decode of read config
    // ******************************
    always_comb begin
        cfg.burst_mode       = ~read_cfg[frc_pkg::RC_MODE]; // RULE2
        cfg.latency          =
            read_cfg[frc_pkg::RC_LAT_HI:frc_pkg::RC_LAT_LO]; // RULE3
        if (cfg.latency < frc_pkg::LAT_MIN) begin
            cfg.latency = frc_pkg::LAT_MIN;
        end else if (cfg.latency > frc_pkg::LAT_MAX) begin
            cfg.latency = frc_pkg::LAT_MAX;
        end
        cfg.wait_active_high = read_cfg[frc_pkg::RC_WAIT_POL]; // RULE5
        cfg.wait_early       = read_cfg[frc_pkg::RC_WAIT_DLY]; // RULE6
        // Reserved burst codes fall back to continuous
        case (read_cfg[2:0]) // RULE7
            frc_pkg::BURST_8: begin
                cfg.burst_words = 5'h08;
                cfg.burst_wrap  = 1'b1;
            end
            frc_pkg::BURST_16: begin
                cfg.burst_words = 5'h10;
                cfg.burst_wrap  = 1'b1;
            end
            default: begin
                cfg.burst_words = 5'h00;
                cfg.burst_wrap  = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: logic/frc_config_regs.sv */
`default_nettype none
module frc_config_regs (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        bus_we_n,
    input  wire logic        bus_oe_n,
    input  wire logic        address_valid_n,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        vpp_ok,
    output logic      [15:0] bus_rdata,
    output logic             bus_rdata_oe,
    output logic      [15:0] read_burst_config,
    output logic      [15:0] power_drive_config,
    output logic      [15:0] status_out,
    output logic      [1:0]  read_mode,
    output logic             burst_mode,
    output logic      [3:0]  latency_cycles,
    output logic             wait_active_high,
    output logic             wait_early,
    output logic      [4:0]  burst_words,
    output logic             burst_wrap,
    output logic             deep_sleep_en,
    output logic             deep_sleep_active_high,
    output logic      [2:0]  drive_strength,
    output logic             latency_start
);
    // ******************************
    // Pin synchronisers
    // ******************************
    logic [35:0] pins_s;
    logic        we_n_s;
    logic        oe_n_s;
    logic        adv_n_s;
    logic [15:0] addr_s;
    logic [15:0] wdata_s;

    frc_sync #(.W(36)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        // Strobes enter inverted so cleared flops read as idle
        .d      ({~bus_we_n, ~bus_oe_n, ~address_valid_n, vpp_ok,
                  bus_addr, bus_wdata}),
        .q      (pins_s)
    );

    assign we_n_s  = ~pins_s[35];
    assign oe_n_s  = ~pins_s[34];
    assign adv_n_s = ~pins_s[33];
    assign addr_s  = pins_s[31:16];
    assign wdata_s = pins_s[15:0];
    // Supply level pins_s[32] is deliberately not used: RULE21

    frc_pkg::frc_rdcfg_s dec;

    frc_decode u_decode (
        .read_cfg (read_burst_config),
        .cfg      (dec)
    );

    // ******************************
    // State
    // ******************************
    typedef struct packed {
        logic [15:0]        rcfg;
        logic [15:0]        pcfg;
        logic [15:0]        status;
        frc_pkg::frc_mode_e mode;
        frc_pkg::frc_seq_e  seq;
        logic [15:0]        held;
        logic               we_d;
        logic               oe_d;
        logic               adv_d;
        logic [15:0]        rdata;
        logic               rdata_oe;
        logic               lat_go;
        logic               lat_seen;
        logic               burst;
        logic [3:0]         lat;
        logic               wpol;
        logic               wdly;
        logic [4:0]         words;
        logic               wrap;
        logic               sleep_en;
        logic               sleep_pol;
        logic [2:0]         drive;
    } frc_state_s;

    frc_state_s st;
    frc_state_s next_st;

    function automatic logic [15:0] info_word(
        input logic [7:0]  ofs,
        input logic [15:0] rc,
        input logic [15:0] pc
    );
        logic [15:0] w;
        w = 16'h0000;
        if (ofs == frc_pkg::OFS_READ_CFG) begin
            w = rc; // RULE11
        end else if (ofs == frc_pkg::OFS_POWER_CFG) begin
            w = pc; // RULE12
        end
        return w;
    endfunction

    logic we_fall;
    logic oe_fall;
    logic adv_rise;
    assign we_fall  = st.we_d & ~we_n_s;
    assign oe_fall  = st.oe_d & ~oe_n_s;
    assign adv_rise = ~st.adv_d & adv_n_s;

    always_comb begin
        next_st       = st;
        next_st.we_d  = we_n_s;
        next_st.oe_d  = oe_n_s;
        next_st.adv_d = adv_n_s;
        next_st.lat_go = 1'b0;
        // Count starts at latch with low, else on next edge after rise
        if (!adv_n_s && st.adv_d) begin
            next_st.lat_go   = dec.burst_mode; // RULE4
            next_st.lat_seen = dec.burst_mode;
        end else if (adv_rise) begin
            // One start per latch: rise counts only if low phase did not
            next_st.lat_go   = dec.burst_mode && !st.lat_seen; // RULE4
            next_st.lat_seen = 1'b0;
        end
        // Write commands, taken at the falling edge of write enable
        if (we_fall) begin
            case (st.seq)
                frc_pkg::SEQ_WAIT: begin
                    next_st.seq = frc_pkg::SEQ_IDLE;
                    if (wdata_s == frc_pkg::CMD_PWR_CONFIRM) begin
                        next_st.pcfg = st.held; // RULE20
                        next_st.mode = frc_pkg::MODE_ARRAY; // RULE20
                    end else if (wdata_s == frc_pkg::CMD_RD_CONFIRM) begin
                        next_st.rcfg = st.held; // RULE10 RULE25
                        next_st.mode = frc_pkg::MODE_ARRAY;
                    end else begin
                        // Foreign write aborts the sequence
                        next_st.status = st.status
                            | frc_pkg::STATUS_SEQ_ERR; // RULE18 RULE24
                        next_st.mode = frc_pkg::MODE_STATUS;
                    end
                end
                default: begin
                    case (wdata_s)
                        frc_pkg::CMD_CFG_SETUP: begin
                            next_st.seq  = frc_pkg::SEQ_WAIT;
                            next_st.held = addr_s;
                            next_st.mode = frc_pkg::MODE_STATUS; // RULE19
                        end
                        frc_pkg::CMD_READ_ARRAY: begin
                            next_st.mode = frc_pkg::MODE_ARRAY;
                        end
                        frc_pkg::CMD_READ_STATUS: begin
                            next_st.mode = frc_pkg::MODE_STATUS;
                        end
                        frc_pkg::CMD_READ_INFO: begin
                            next_st.mode = frc_pkg::MODE_INFO;
                        end
                        frc_pkg::CMD_CFI_QUERY: begin
                            next_st.mode = frc_pkg::MODE_CFI;
                        end
                        frc_pkg::CMD_CLEAR_STATUS: begin
                            next_st.status = frc_pkg::STATUS_READY;
                            next_st.mode   = frc_pkg::MODE_STATUS;
                        end
                        default: begin
                            next_st.mode = st.mode;
                        end
                    endcase
                end
            endcase
        end
        // Reads between setup and confirm are allowed and harmless
        if (oe_fall) begin
            next_st.rdata_oe = 1'b1;
            case (st.mode)
                frc_pkg::MODE_STATUS: next_st.rdata = st.status;
                frc_pkg::MODE_INFO: begin
                    next_st.rdata = info_word(addr_s[7:0], st.rcfg,
                                              st.pcfg);
                end
                default: next_st.rdata = 16'h0000;
            endcase
        end else if (oe_n_s) begin
            next_st.rdata_oe = 1'b0;
        end
        // Timing fields ignored in async mode
        next_st.burst = dec.burst_mode; // RULE1
        next_st.lat   = dec.burst_mode ? dec.latency : st.lat; // RULE1
        next_st.wpol  = dec.burst_mode ? dec.wait_active_high : st.wpol;
        next_st.wdly  = dec.burst_mode ? dec.wait_early : st.wdly;
        next_st.words = dec.burst_mode ? dec.burst_words : st.words;
        next_st.wrap  = dec.burst_mode ? dec.burst_wrap : st.wrap;
        next_st.sleep_en  = st.pcfg[frc_pkg::PC_SLEEP_EN]; // RULE14
        next_st.sleep_pol = st.pcfg[frc_pkg::PC_SLEEP_POL]; // RULE15
        // Reserved drive codes keep the last legal strength
        if (st.pcfg[2:0] >= frc_pkg::DRIVE_MIN
            && st.pcfg[2:0] <= frc_pkg::DRIVE_MAX) begin
            next_st.drive = st.pcfg[2:0]; // RULE16
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st           <= '0;
            st.rcfg      <= frc_pkg::READ_CFG_RESET; // RULE1
            st.pcfg      <= frc_pkg::POWER_CFG_RESET; // RULE13
            st.status    <= frc_pkg::STATUS_READY;
            st.mode      <= frc_pkg::MODE_ARRAY;
            st.seq       <= frc_pkg::SEQ_IDLE;
            st.we_d      <= 1'b1;
            st.oe_d      <= 1'b1;
            st.adv_d     <= 1'b1;
            st.lat       <= frc_pkg::LAT_MIN;
            st.wdly      <= 1'b1;
            st.words     <= 5'h00;
            st.drive     <= frc_pkg::POWER_CFG_RESET[2:0];
        end else begin
            st <= next_st;
        end
    end

    // ******************************
    // Outputs
    // ******************************
    assign bus_rdata              = st.rdata;
    assign bus_rdata_oe           = st.rdata_oe;
    assign read_burst_config      = st.rcfg;
    assign power_drive_config     = st.pcfg;
    assign status_out             = st.status;
    assign read_mode              = st.mode;
    assign burst_mode             = st.burst;
    assign latency_cycles         = st.lat;
    assign wait_active_high       = st.wpol;
    assign wait_early             = st.wdly;
    assign burst_words            = st.words;
    assign burst_wrap             = st.wrap;
    assign deep_sleep_en          = st.sleep_en;
    assign deep_sleep_active_high = st.sleep_pol;
    assign drive_strength         = st.drive;
    assign latency_start          = st.lat_go;

    // ******************************
    // Checks
    // ******************************
    sequence s_setup;
        we_fall && st.seq == frc_pkg::SEQ_IDLE
            && wdata_s == frc_pkg::CMD_CFG_SETUP;
    endsequence

    sequence s_confirm;
        we_fall && st.seq == frc_pkg::SEQ_WAIT
            && wdata_s == frc_pkg::CMD_PWR_CONFIRM;
    endsequence

    a_setup_status: assert property (@(posedge clk) disable iff (!resetn)
        s_setup |=> st.mode == frc_pkg::MODE_STATUS) // RULE19
        else $error("setup did not enter status mode");

    a_confirm_loads: assert property (@(posedge clk) disable iff (!resetn)
        s_confirm |=> st.pcfg == $past(st.held)
            && st.mode == frc_pkg::MODE_ARRAY) // RULE20
        else $error("confirm did not load power config");

    a_seq_error: assert property (@(posedge clk) disable iff (!resetn)
        we_fall && st.seq == frc_pkg::SEQ_WAIT
            && wdata_s != frc_pkg::CMD_PWR_CONFIRM
            && wdata_s != frc_pkg::CMD_RD_CONFIRM
        |=> st.status[5:4] == 2'b11) // RULE18
        else $error("sequence error not flagged");

    a_rcfg_stable: assert property (@(posedge clk) disable iff (!resetn)
        !(we_fall && st.seq == frc_pkg::SEQ_WAIT) |=> $stable(st.rcfg))
        // RULE10
        else $error("read config changed without command");

    a_info_rcfg: assert property (@(posedge clk) disable iff (!resetn)
        oe_fall && st.mode == frc_pkg::MODE_INFO
            && addr_s[7:0] == frc_pkg::OFS_READ_CFG
        |=> bus_rdata == $past(st.rcfg) && bus_rdata_oe) // RULE11
        else $error("info read of read config wrong");

    a_info_pcfg: assert property (@(posedge clk) disable iff (!resetn)
        oe_fall && st.mode == frc_pkg::MODE_INFO
            && addr_s[7:0] == frc_pkg::OFS_POWER_CFG
        |=> bus_rdata == $past(st.pcfg)) // RULE12
        else $error("info read of power config wrong");

    a_sleep_follow: assert property (@(posedge clk) disable iff (!resetn)
        ##1 deep_sleep_en == $past(st.pcfg[frc_pkg::PC_SLEEP_EN])
            && deep_sleep_active_high
                == $past(st.pcfg[frc_pkg::PC_SLEEP_POL])) // RULE14
        else $error("deep sleep controls stale");

    a_drive_legal: assert property (@(posedge clk) disable iff (!resetn)
        drive_strength >= frc_pkg::DRIVE_MIN
            && drive_strength <= frc_pkg::DRIVE_MAX) // RULE16
        else $error("drive strength code reserved");

    a_async_hold: assert property (@(posedge clk) disable iff (!resetn)
        !burst_mode ##1 !burst_mode |-> !latency_start) // RULE1
        else $error("latency started in async mode");
endmodule
`default_nettype wire

/* File: tb/frc_host.sv */
`default_nettype none
// ************************************************************
// Host memory controller model on the flash pins
// ************************************************************
module frc_host (
    input  wire logic        clk,
    input  wire logic [15:0] bus_rdata,
    input  wire logic        bus_rdata_oe,
    output logic             bus_we_n,
    output logic             bus_oe_n,
    output logic             address_valid_n,
    output logic      [15:0] bus_addr,
    output logic      [15:0] bus_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_we_n        = 1'b1;
        bus_oe_n        = 1'b1;
        address_valid_n = 1'b1;
        bus_addr        = 16'h0000;
        bus_wdata       = 16'h0000;
    end

    // Pins held five clocks so the two-flop sync always sees them
    task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        bus_addr  = a;
        bus_wdata = d;
        bus_we_n  = 1'b0;
        repeat (5) @(negedge clk);
        bus_we_n = 1'b1;
        repeat (5) @(negedge clk);
        // Undriven lines drift, never keep the old value
        bus_addr  = ~a;
        bus_wdata = ~d;
    endtask

    task automatic bus_read(input logic [15:0] a, output logic [15:0] d,
                            output logic oe);
        @(negedge clk);
        bus_addr = a;
        bus_oe_n = 1'b0;
        repeat (5) @(negedge clk);
        d        = bus_rdata;
        oe       = bus_rdata_oe;
        bus_oe_n = 1'b1;
        repeat (5) @(negedge clk);
        bus_addr = ~a;
    endtask

    // Value on the address lines, nothing written between the two cycles
    task automatic cfg_write(input logic [15:0] v, input logic [15:0] cf);
        bus_write(v, frc_pkg::CMD_CFG_SETUP);
        bus_write(v, cf);
    endtask

    task automatic info_read(input logic [7:0] ofs, output logic [15:0] d,
                             output logic oe);
        bus_write(16'h0000, frc_pkg::CMD_READ_INFO);
        bus_read({8'h00, ofs}, d, oe);
    endtask

    task automatic latch_addr(input logic [15:0] a);
        @(negedge clk);
        bus_addr        = a;
        address_valid_n = 1'b0;
        repeat (5) @(negedge clk);
        address_valid_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        resetn;
    logic        vpp_ok;
    logic        we_n;
    logic        oe_n;
    logic        adv_n;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rdata_oe;
    logic [15:0] rcfg;
    logic [15:0] pcfg;
    logic [15:0] status;
    logic [1:0]  mode;
    logic        burst_mode;
    logic [3:0]  latency;
    logic        wait_hi;
    logic        wait_early;
    logic [4:0]  words;
    logic        wrap;
    logic        sleep_en;
    logic        sleep_hi;
    logic [2:0]  drive;
    logic        lat_start;
    int          error_cnt;
    int          cmp_count;
    int          lat_pulses;
    logic [15:0] rd;
    logic        oe;

    // Reserved bits zero; no table entry uses latency code 2
    logic [15:0] rc_val [3] = '{16'h5402, 16'h1903, 16'h6007};
    logic [3:0]  rc_lat [3] = '{4'ha, 4'h3, 4'hc};
    logic [2:0]  rc_wtf [3] = '{3'h2, 3'h1, 3'h0};
    logic [5:0]  rc_bur [3] = '{6'h11, 6'h21, 6'h00};

    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (lat_start === 1'b1) lat_pulses++;

    frc_host u_host (
        .clk             (clk),
        .bus_rdata       (rdata),
        .bus_rdata_oe    (rdata_oe),
        .bus_we_n        (we_n),
        .bus_oe_n        (oe_n),
        .address_valid_n (adv_n),
        .bus_addr        (addr),
        .bus_wdata       (wdata)
    );

    frc_config_regs u_dut (
        .clk                    (clk),
        .resetn                 (resetn),
        .bus_we_n               (we_n),
        .bus_oe_n               (oe_n),
        .address_valid_n        (adv_n),
        .bus_addr               (addr),
        .bus_wdata              (wdata),
        .vpp_ok                 (vpp_ok),
        .bus_rdata              (rdata),
        .bus_rdata_oe           (rdata_oe),
        .read_burst_config      (rcfg),
        .power_drive_config     (pcfg),
        .status_out             (status),
        .read_mode              (mode),
        .burst_mode             (burst_mode),
        .latency_cycles         (latency),
        .wait_active_high       (wait_hi),
        .wait_early             (wait_early),
        .burst_words            (words),
        .burst_wrap             (wrap),
        .deep_sleep_en          (sleep_en),
        .deep_sleep_active_high (sleep_hi),
        .drive_strength         (drive),
        .latency_start          (lat_start)
    );

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic test_reset_values();
        chk("rcfg", 16'hb907, rcfg);
        chk("burst_mode", 16'h0000, 16'(burst_mode));
        chk("pcfg", 16'h0004, pcfg);
        chk("sleep_en", 16'h0000, 16'(sleep_en));
        chk("sleep_hi", 16'h0000, 16'(sleep_hi));
        chk("drive", 16'h0004, 16'(drive));
        chk("wait_hi", 16'h0000, 16'(wait_hi));
        chk("wait_early", 16'h0001, 16'(wait_early));
        chk("status", 16'h0080, status);
        chk("mode", 16'h0000, 16'(mode));
        lat_pulses = 0;
        u_host.latch_addr(16'h0100);
        chk("async latch", 16'h0000, 16'(lat_pulses));
        u_host.info_read(8'h05, rd, oe);
        chk("info 05", 16'hb907, rd);
        chk("info oe", 16'h0001, 16'(oe));
        u_host.info_read(8'h06, rd, oe);
        chk("info 06", 16'h0004, rd);
        u_host.info_read(8'h07, rd, oe);
        chk("info 07", 16'h0000, rd);
        $display("test reset_values done");
    endtask

    task automatic test_power_write();
        vpp_ok = 1'b0;
        u_host.bus_write(16'hc005, frc_pkg::CMD_CFG_SETUP);
        chk("mode setup", 16'h0001, 16'(mode));
        u_host.bus_read(16'h0000, rd, oe);
        chk("status read", 16'h0080, status);
        chk("status rd", 16'h0080, rd);
        u_host.bus_write(16'hc005, frc_pkg::CMD_PWR_CONFIRM);
        chk("pcfg", 16'hc005, pcfg);
        chk("mode confirm", 16'h0000, 16'(mode));
        chk("sleep_en", 16'h0001, 16'(sleep_en));
        chk("sleep_hi", 16'h0001, 16'(sleep_hi));
        chk("drive", 16'h0005, 16'(drive));
        vpp_ok = 1'b1;
        u_host.info_read(8'h06, rd, oe);
        chk("info 06", 16'hc005, rd);
        u_host.cfg_write(16'h0007, frc_pkg::CMD_PWR_CONFIRM);
        chk("drive reserved", 16'h0005, 16'(drive));
        $display("test power_write done");
    endtask

    task automatic test_read_cfg();
        for (int i = 0; i < 3; i++) begin
            u_host.cfg_write(rc_val[i], frc_pkg::CMD_RD_CONFIRM);
            chk("rcfg", rc_val[i], rcfg);
            chk("burst_mode", 16'h0001, 16'(burst_mode));
            chk("latency", 16'(rc_lat[i]), 16'(latency));
            chk("wait_hi", 16'(rc_wtf[i][1]), 16'(wait_hi));
            chk("wait_early", 16'(rc_wtf[i][0]), 16'(wait_early));
            chk("burst_words", 16'(rc_bur[i][5:1]), 16'(words));
            chk("burst_wrap", 16'(rc_bur[i][0]), 16'(wrap));
            lat_pulses = 0;
            u_host.latch_addr(16'h0200);
            chk("latch pulse", 16'h0001, 16'(lat_pulses));
        end
        u_host.info_read(8'h05, rd, oe);
        chk("info 05", rc_val[2], rd);
        $display("test read_cfg done");
    endtask

    task automatic test_seq_error();
        u_host.bus_write(16'h8004, frc_pkg::CMD_CFG_SETUP);
        u_host.bus_write(16'h0000, frc_pkg::CMD_READ_ARRAY);
        chk("status err", 16'h0003, 16'(status[5:4]));
        chk("mode err", 16'h0001, 16'(mode));
        chk("pcfg kept", 16'h0007, pcfg);
        u_host.bus_write(16'h8004, frc_pkg::CMD_PWR_CONFIRM);
        chk("pcfg lone", 16'h0007, pcfg);
        u_host.bus_write(16'h8004, frc_pkg::CMD_RD_CONFIRM);
        chk("rcfg lone", 16'h6007, rcfg);
        u_host.bus_write(16'h0000, frc_pkg::CMD_CLEAR_STATUS);
        chk("status clr", 16'h0080, status);
        u_host.bus_write(16'h0000, frc_pkg::CMD_CFI_QUERY);
        chk("mode cfi", 16'h0003, 16'(mode));
        u_host.bus_write(16'h0000, frc_pkg::CMD_READ_STATUS);
        chk("mode status", 16'h0001, 16'(mode));
        $display("test seq_error done");
    endtask

    task automatic test_reset_again();
        do_reset();
        chk("pcfg", 16'h0004, pcfg);
        chk("rcfg", 16'hb907, rcfg);
        chk("drive", 16'h0004, 16'(drive));
        chk("burst_mode", 16'h0000, 16'(burst_mode));
        $display("test reset_again done");
    endtask

    // Whole sequence needs well under 20 us at 5 ns per clock
    initial begin
        #100000;
        error_cnt++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        resetn     = 1'b0;
        vpp_ok     = 1'b1;
        error_cnt  = 0;
        cmp_count  = 0;
        lat_pulses = 0;
        do_reset();
        test_reset_values();
        test_power_write();
        test_read_cfg();
        test_seq_error();
        test_reset_again();
        end_sim();
    end
endmodule
`default_nettype wire
